// ---- hdl/dcf_pkg.sv ----
// shared constants and pin bundle for the dual-clock byte fifo
package dcf_pkg;
	localparam int DATA_W = 8;
	localparam int DEPTH_DEFAULT = 64;
	localparam int DEPTH_MIN = 16;
	localparam int DEPTH_MAX = 4096;
	localparam int FULL_MARGIN = 7; // almost-full at depth minus this
	localparam int EMPTY_MARGIN = 7; // almost-empty up to this occupancy
	localparam logic FULL_N_RST = 1'h1;
	localparam logic ALMOST_FULL_N_RST = 1'h1;
	localparam logic EMPTY_N_RST = 1'h0;
	localparam logic ALMOST_EMPTY_N_RST = 1'h0;
	localparam logic [DATA_W-1:0] READ_DATA_RST = 8'h00;

	// all external pins that must be brought into the CLK domain
	typedef struct packed {
		logic wclk;
		logic rclk;
		logic reset_n;
		logic write_en_n;
		logic read_en_n;
		logic out_en_n;
		logic [DATA_W-1:0] write_data;
	} dcf_pins_s;
endpackage : dcf_pkg

// ---- hdl/dcf_pin_sync.sv ----
// two-stage pin synchroniser with a third stage for rising-edge detection
`timescale 1ns/100ps
module dcf_pin_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] s1_q, s2_q, s3_q;
	logic [W-1:0] s1_d, s2_d, s3_d;

	initial begin
		if (W < 1) $error("dcf_pin_sync: W must be at least 1");
	end

	// next values of the shift chain
	always_comb begin
		s1_d = pin_in;
		s2_d = s1_q;
		s3_d = s2_q;
	end

	// chain registers, first stage read only by the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	assign level = s2_q;
	assign rise = s2_q & ~s3_q;
endmodule : dcf_pin_sync

// ---- hdl/dcf_byte_fifo.sv ----
// byte fifo with write-side and read-side clock pins and four status flags
`timescale 1ns/100ps
// Operation
// - full low at depth, stores refused
// - full flags change only on write edges or while reset_n is low
// - empty low when pointers equal, fetches suppressed
// - empty flags change only on read edges or while reset_n is low
// - almost-full low after depth minus seven stores
// - almost-empty high after eight stores
// - flags follow occupancy bands
// - full may defer to next write edge
// - empty may defer to next read edge
// - partial flags use same deferral, longer skew
// - first word readable within two read periods
// - almost-full asserts at depth minus seven
// - almost-empty asserts at seven words
// - after reset data zero or released
// - clocks may run during reset
// - reset clears pointers, flags, output register
// - write enable low stores, ignored when full
// - read enable low fetches, else hold
// - output enable low drives data out
module dcf_byte_fifo import dcf_pkg::*; #(
	parameter int DEPTH = DEPTH_DEFAULT
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic WCLK,
	input wire logic RCLK,
	input wire logic RESET_N,
	input wire logic WRITE_EN_N,
	input wire logic READ_EN_N,
	input wire logic OUT_EN_N,
	input wire logic [DATA_W-1:0] WRITE_DATA,
	output logic [DATA_W-1:0] READ_DATA,
	output logic READ_DATA_OE,
	output logic FULL_N,
	output logic ALMOST_FULL_N,
	output logic EMPTY_N,
	output logic ALMOST_EMPTY_N
);
	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	localparam logic [PW-1:0] OCC_FULL = PW'(DEPTH);
	localparam logic [PW-1:0] OCC_AFULL = PW'(DEPTH - FULL_MARGIN);
	localparam logic [PW-1:0] OCC_AEMPTY = PW'(EMPTY_MARGIN);

	// power-of-two depth inside the supported range
	initial begin
		if (DEPTH < DEPTH_MIN || DEPTH > DEPTH_MAX || (DEPTH & (DEPTH - 1)) != 0)
			$error("dcf_byte_fifo: DEPTH must be a power of two in range");
	end

	function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
		return b ^ (b >> 1);
	endfunction : bin2gray

	function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b = g;
		for (int i = PW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : gray2bin

	// pin synchronisers
	dcf_pins_s pins_raw, pins_lvl, pins_rise;
	assign pins_raw = '{wclk: WCLK, rclk: RCLK, reset_n: RESET_N, write_en_n: WRITE_EN_N,
		read_en_n: READ_EN_N, out_en_n: OUT_EN_N, write_data: WRITE_DATA};

	dcf_pin_sync #(.W($bits(dcf_pins_s))) u_sync (
		.clk(CLK),
		.rst(RST),
		.pin_in(pins_raw),
		.level(pins_lvl),
		.rise(pins_rise)
	);

	logic w_edge, r_edge, run, we, re;
	assign w_edge = pins_rise.wclk;
	assign r_edge = pins_rise.rclk;
	assign run = pins_lvl.reset_n; // clocks may toggle while this is low

	logic [DATA_W-1:0] mem [DEPTH];
	logic [PW-1:0] wbin_q, wbin_d, wgray_q, wgray_d, wocc_q, wocc_d;
	logic [PW-1:0] rbin_q, rbin_d, rgray_q, rgray_d, rocc_q, rocc_d;
	logic [PW-1:0] rgray_to_w_q, wgray_to_r_q;
	logic full_n_q, full_n_d, afull_n_q, afull_n_d;
	logic empty_n_q, empty_n_d, aempty_n_q, aempty_n_d;
	logic [DATA_W-1:0] dout_q, dout_d;

	// accepted store and fetch
	assign we = w_edge & run & ~pins_lvl.write_en_n & full_n_q;
	assign re = r_edge & run & ~pins_lvl.read_en_n & empty_n_q;

	// write side next state, flags move only on write edges or while reset_n is low
	always_comb begin
		wbin_d = wbin_q;
		wocc_d = wocc_q;
		full_n_d = full_n_q;
		afull_n_d = afull_n_q;
		if (!run) begin
			wbin_d = '0;
			wocc_d = '0;
			full_n_d = FULL_N_RST;
			afull_n_d = ALMOST_FULL_N_RST;
		end else if (w_edge) begin
			wbin_d = we ? PW'(wbin_q + 1'b1) : wbin_q;
			// read pointer as last seen via its gray copy
			wocc_d = PW'(wbin_d - gray2bin(rgray_to_w_q));
			full_n_d = (wocc_d != OCC_FULL);
			afull_n_d = (wocc_d < OCC_AFULL);
		end
		wgray_d = bin2gray(wbin_d);
	end

	// write side registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wbin_q <= '0;
			wgray_q <= '0;
			wocc_q <= '0;
			full_n_q <= FULL_N_RST;
			afull_n_q <= ALMOST_FULL_N_RST;
		end else begin
			wbin_q <= wbin_d;
			wgray_q <= wgray_d;
			wocc_q <= wocc_d;
			full_n_q <= full_n_d;
			afull_n_q <= afull_n_d;
		end
	end

	// storage array, no reset needed
	always_ff @(posedge CLK) begin
		if (we)
			mem[wbin_q[AW-1:0]] <= pins_lvl.write_data;
	end

	// read side next state, flags move only on read edges or while reset_n is low
	always_comb begin
		rbin_d = rbin_q;
		rocc_d = rocc_q;
		empty_n_d = empty_n_q;
		aempty_n_d = aempty_n_q;
		dout_d = dout_q;
		if (!run) begin
			rbin_d = '0;
			rocc_d = '0;
			empty_n_d = EMPTY_N_RST;
			aempty_n_d = ALMOST_EMPTY_N_RST;
			dout_d = READ_DATA_RST;
		end else if (r_edge) begin
			if (re) begin
				rbin_d = PW'(rbin_q + 1'b1);
				dout_d = mem[rbin_q[AW-1:0]];
			end
			// write pointer as last seen via its gray copy
			rocc_d = PW'(gray2bin(wgray_to_r_q) - rbin_d);
			empty_n_d = (rocc_d != '0);
			aempty_n_d = (rocc_d > OCC_AEMPTY);
		end
		rgray_d = bin2gray(rbin_d);
	end

	// read side registers and cross copies of the gray pointers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rbin_q <= '0;
			rgray_q <= '0;
			rocc_q <= '0;
			empty_n_q <= EMPTY_N_RST;
			aempty_n_q <= ALMOST_EMPTY_N_RST;
			dout_q <= READ_DATA_RST;
			rgray_to_w_q <= '0;
			wgray_to_r_q <= '0;
		end else begin
			rbin_q <= rbin_d;
			rgray_q <= rgray_d;
			rocc_q <= rocc_d;
			empty_n_q <= empty_n_d;
			aempty_n_q <= aempty_n_d;
			dout_q <= dout_d;
			rgray_to_w_q <= rgray_q;
			wgray_to_r_q <= wgray_q;
		end
	end

	// pins
	assign READ_DATA = dout_q;
	assign READ_DATA_OE = ~pins_lvl.out_en_n;
	assign FULL_N = full_n_q;
	assign ALMOST_FULL_N = afull_n_q;
	assign EMPTY_N = empty_n_q;
	assign ALMOST_EMPTY_N = aempty_n_q;

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_full_depth;
		$fell(FULL_N) |-> (wocc_q == OCC_FULL);
	endproperty
	a_full_depth: assert property (p_full_depth) else $error("full fell below depth");

	property p_full_edge;
		(!w_edge && run) |=> ($stable(FULL_N) && $stable(ALMOST_FULL_N));
	endproperty
	a_full_edge: assert property (p_full_edge) else $error("full flag moved off write edge");

	property p_no_fetch_empty;
		(r_edge && !EMPTY_N) |=> ($stable(rbin_q) || !$past(run));
	endproperty
	a_no_fetch_empty: assert property (p_no_fetch_empty) else $error("fetch while empty");

	property p_empty_edge;
		(!r_edge && run) |=> ($stable(EMPTY_N) && $stable(ALMOST_EMPTY_N));
	endproperty
	a_empty_edge: assert property (p_empty_edge) else $error("empty flag moved off read edge");

	property p_afull_level;
		$fell(ALMOST_FULL_N) |-> (wocc_q >= OCC_AFULL);
	endproperty
	a_afull_level: assert property (p_afull_level) else $error("almost-full fell early");

	property p_aempty_level;
		$rose(ALMOST_EMPTY_N) |-> (rocc_q > OCC_AEMPTY);
	endproperty
	a_aempty_level: assert property (p_aempty_level) else $error("almost-empty rose early");

	property p_reset_state;
		!run |=> (READ_DATA == READ_DATA_RST && FULL_N && ALMOST_FULL_N && !EMPTY_N && !ALMOST_EMPTY_N);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

	property p_store_advance;
		we |=> (wbin_q == PW'($past(wbin_q) + 1'b1));
	endproperty
	a_store_advance: assert property (p_store_advance) else $error("store did not advance");

	property p_out_hold;
		(!re && run) |=> $stable(READ_DATA);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output changed without fetch");

	c_full: cover property ($fell(FULL_N));
	c_afull: cover property ($fell(ALMOST_FULL_N));
	c_leave_empty: cover property ($rose(EMPTY_N) ##[1:20] re);
endmodule : dcf_byte_fifo

// ---- verification/dcf_port_model.sv ----
// producer and consumer model driving the clock pins of both sides
`timescale 1ns/100ps
module dcf_port_model import dcf_pkg::*; (
	input wire logic clk,
	output logic wclk,
	output logic rclk,
	output logic write_en_n,
	output logic read_en_n,
	output logic [DATA_W-1:0] write_data
);
	// clocks stand still between frames
	initial begin
		wclk = 1'h0;
		rclk = 1'h0;
		write_en_n = 1'h1;
		read_en_n = 1'h1;
		write_data = 8'h5A;
	end

	// one write frame, enable and data held around the rise
	task automatic put(input logic [DATA_W-1:0] d, input logic en);
		@(posedge clk);
		write_en_n <= ~en;
		write_data <= d;
		repeat (3) @(posedge clk);
		wclk <= 1'h1;
		repeat (4) @(posedge clk);
		wclk <= 1'h0;
		repeat (4) @(posedge clk);
		write_en_n <= 1'h1;
		write_data <= ~d; // released data does not linger
	endtask : put

	// one read frame, enable held around the rise
	task automatic get(input logic en);
		@(posedge clk);
		read_en_n <= ~en;
		repeat (3) @(posedge clk);
		rclk <= 1'h1;
		repeat (4) @(posedge clk);
		rclk <= 1'h0;
		repeat (4) @(posedge clk);
		read_en_n <= 1'h1;
	endtask : get
endmodule : dcf_port_model

// ---- verification/dual_clock_byte_fifo_flags_tb.sv ----
// self-checking bench for the dual-clock byte fifo
`timescale 1ns/100ps
module dual_clock_byte_fifo_flags_tb import dcf_pkg::*;;
	localparam int D = 16;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic reset_n = 1'h1;
	logic out_en_n = 1'h0;
	logic wclk, rclk, wen_n, ren_n, oe, full_n, afull_n, empty_n, aempty_n;
	logic [DATA_W-1:0] wdata, rdata;
	logic wide_n = 1'h0; // low: side by side, high: depth expansion
	logic sel_w = 1'h0;
	logic sel_r = 1'h0;
	logic wen_a, wen_b, ren_a, ren_b, oe_b, full_b, afull_b, empty_b, aempty_b;
	logic [DATA_W-1:0] wdata_b, rdata_b;
	logic [7:0] flags;
	int miscompares = 0;
	int checks_done = 0;

	// clock and flag bundle
	always #2 clk = ~clk;
	assign flags = {4'h0, full_n & full_b, afull_n, empty_n & empty_b, aempty_n};

	// expansion steering: shared controls side by side, alternating for depth
	assign wen_a = wen_n | (wide_n & sel_w);
	assign wen_b = wen_n | (wide_n & ~sel_w);
	assign ren_a = ren_n | (wide_n & sel_r);
	assign ren_b = ren_n | (wide_n & ~sel_r);
	assign wdata_b = wide_n ? wdata : ~wdata;

	dcf_port_model m (.clk(clk), .wclk(wclk), .rclk(rclk), .write_en_n(wen_n),
		.read_en_n(ren_n), .write_data(wdata));

	dcf_byte_fifo #(.DEPTH(D)) uut (.CLK(clk), .RST(rst), .WCLK(wclk), .RCLK(rclk),
		.RESET_N(reset_n), .WRITE_EN_N(wen_a), .READ_EN_N(ren_a), .OUT_EN_N(out_en_n),
		.WRITE_DATA(wdata), .READ_DATA(rdata), .READ_DATA_OE(oe), .FULL_N(full_n),
		.ALMOST_FULL_N(afull_n), .EMPTY_N(empty_n), .ALMOST_EMPTY_N(aempty_n));

	// second device: upper byte lane side by side, or second bank in depth
	dcf_byte_fifo #(.DEPTH(D)) uut_b (.CLK(clk), .RST(rst), .WCLK(wclk), .RCLK(rclk),
		.RESET_N(reset_n), .WRITE_EN_N(wen_b), .READ_EN_N(ren_b), .OUT_EN_N(out_en_n),
		.WRITE_DATA(wdata_b), .READ_DATA(rdata_b), .READ_DATA_OE(oe_b), .FULL_N(full_b),
		.ALMOST_FULL_N(afull_b), .EMPTY_N(empty_b), .ALMOST_EMPTY_N(aempty_b));

	// expected flags from occupancy seen by each side
	function automatic logic [7:0] fl(input int w, input int r);
		fl = {4'h0, w < D, w < D - 7, r > 0, r > 7};
	endfunction : fl

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic print_verdict;
		if (miscompares == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	task automatic t_reset;
		chk(flags, fl(0, 0));
		chk(rdata, 8'h00);
		chk({7'h0, oe}, 8'h01);
		@(posedge clk);
		out_en_n <= 1'h1;
		repeat (4) @(posedge clk);
		chk({7'h0, oe}, 8'h00);
		out_en_n <= 1'h0;
		repeat (4) @(posedge clk);
	endtask : t_reset

	task automatic t_fill;
		for (int i = 1; i <= D; i++) begin
			m.put(8'h30 + 8'(i), 1'h1);
			chk(flags, fl(i, 0));
		end
		m.put(8'hEE, 1'h1);
		chk(flags, fl(D, 0));
	endtask : t_fill

	task automatic t_drain;
		m.get(1'h0);
		chk(flags, fl(D, D));
		chk(rdata, 8'h00);
		for (int i = 1; i <= D; i++) begin
			m.get(1'h1);
			chk(rdata, 8'h30 + 8'(i));
			chk(rdata_b, ~(8'h30 + 8'(i)));
			chk(flags, fl(D, D - i));
		end
		m.get(1'h1);
		chk(rdata, 8'h30 + 8'(D));
		m.put(8'h55, 1'h0);
		chk(flags, fl(0, 0));
	endtask : t_drain

	task automatic t_first;
		m.put(8'hA5, 1'h1);
		m.get(1'h1);
		chk(rdata, 8'h30 + 8'(D));
		chk(flags, fl(1, 1));
		m.get(1'h1);
		chk(rdata, 8'hA5);
		chk(flags, fl(1, 0));
	endtask : t_first

	task automatic t_midreset;
		m.put(8'h11, 1'h1);
		m.put(8'h22, 1'h1);
		@(posedge clk);
		reset_n <= 1'h0;
		m.put(8'h33, 1'h1);
		m.get(1'h1);
		chk(flags, fl(0, 0));
		chk(rdata, 8'h00);
		reset_n <= 1'h1;
		repeat (4) @(posedge clk);
		m.put(8'h44, 1'h1);
		m.get(1'h0);
		m.get(1'h1);
		chk(rdata, 8'h44);
		chk(flags, fl(1, 0));
	endtask : t_midreset

	// two devices in depth, accesses alternate between them
	task automatic t_depth;
		wide_n <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			sel_w <= i[0];
			m.put(8'h61 + 8'(i), 1'h1);
		end
		m.get(1'h0);
		chk(flags, fl(2, 2));
		for (int i = 0; i < 4; i++) begin
			sel_r <= i[0];
			m.get(1'h1);
			chk(i[0] ? rdata_b : rdata, 8'h61 + 8'(i));
		end
		chk(flags, fl(2, 0));
		wide_n <= 1'h0;
	endtask : t_depth

	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		repeat (4) @(posedge clk);
		t_reset();
		t_fill();
		t_drain();
		t_first();
		t_midreset();
		t_depth();
		print_verdict();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
endmodule : dual_clock_byte_fifo_flags_tb
